// [core/rcg_pkg.sv]
package rcg_pkg;
   localparam int          NUM_UNITS     = 5;
   localparam int          ADDR_W        = 12;
   localparam int          TICK_W        = 16;
   localparam logic [11:0] RUN_OFF       = 12'h100;
   localparam logic [11:0] STAT_OFF      = 12'h104;
   localparam logic [11:0] MASK_OFF      = 12'h108;
   localparam logic [31:0] RUN_RESET     = 32'h0000_0040;
   localparam logic [31:0] RUN_WMASK     = 32'h0111_0348;
   localparam logic [4:0]  STAT_RESET    = 5'h00;
   localparam logic [4:0]  MASK_RESET    = 5'h00;
   // Bit positions in run_clock_gate_reg
   localparam int          DOG_TIMER_CLK_EN_BIT        = 3;
   localparam int          LOW_POWER_KEEPER_CLK_EN_BIT = 6;
   localparam int          CONV_CLK_EN_BIT             = 16;
   localparam int          PWM_CLK_EN_BIT              = 20;
   localparam int          MSG_CTRL_CLK_EN_BIT         = 24;
   localparam int          RATE_LSB      = 8;
   localparam int          RATE_MSB      = 9;
   // Unit index in the enable vectors
   localparam int          U_DOG         = 0;
   localparam int          U_KEEP        = 1;
   localparam int          U_CONV        = 2;
   localparam int          U_PWM         = 3;
   localparam int          U_MSG         = 4;
   localparam logic [1:0]  RATE_125K     = 2'h0;
   localparam logic [1:0]  RATE_250K     = 2'h1;
   localparam logic [1:0]  RATE_500K     = 2'h2;
   localparam int          CLK_PERIOD_NS = 20;
   localparam int          PER_125K_NS   = 8000;
   localparam int          PER_250K_NS   = 4000;
   localparam int          PER_500K_NS   = 2000;
   localparam int          CYC_125K      = PER_125K_NS / CLK_PERIOD_NS;
   localparam int          CYC_250K      = PER_250K_NS / CLK_PERIOD_NS;
   localparam int          CYC_500K      = PER_500K_NS / CLK_PERIOD_NS;

   function automatic logic [4:0] unit_bits(input logic [31:0] w);
      return {w[MSG_CTRL_CLK_EN_BIT], w[PWM_CLK_EN_BIT], w[CONV_CLK_EN_BIT],
              w[LOW_POWER_KEEPER_CLK_EN_BIT], w[DOG_TIMER_CLK_EN_BIT]};
   endfunction

   function automatic logic get_bit(input logic [31:0] w, input int i);
      return w[i];
   endfunction

   function automatic logic [TICK_W-1:0] rate_cycles(input logic [1:0] code);
      if (code == RATE_500K) begin
         return TICK_W'(CYC_500K);
      end else if (code == RATE_250K) begin
         return TICK_W'(CYC_250K);
      end else begin
         return TICK_W'(CYC_125K);
      end
   endfunction
endpackage

// [core/rcg_unit_if.sv]
`timescale 1ns/100ps
interface rcg_unit_if #(parameter int N = 5);
   logic [N-1:0] en;
   logic [N-1:0] acc_req;
   logic [N-1:0] fault;
   modport core (output en, output acc_req, input fault);
   modport gate (input en);
   modport chk  (input en, input acc_req, output fault);
endinterface

// [core/rcg_clk_gate.sv]
`timescale 1ns/100ps
module rcg_clk_gate
   import rcg_pkg::*;
#(
   parameter int           N      = NUM_UNITS,
   parameter logic [N-1:0] RST_EN = '0
) (
   input  wire logic   clk,
   input  wire logic   reset,
   rcg_unit_if.gate    u,
   output logic [N-1:0] gclk
);
   typedef struct packed {
      logic [N-1:0] en_lo;
   } rcg_gate_state_t;

   rcg_gate_state_t st_r;
   rcg_gate_state_t st_nxt;

   // Enable is taken on the falling clock edge, so a pulse is never cut short
   always_comb begin
      st_nxt       = st_r;
      st_nxt.en_lo = u.en;
   end

   always_ff @(negedge clk or posedge reset) begin
      if (reset) begin
         st_r.en_lo <= RST_EN;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign gclk = {N{clk}} & st_r.en_lo;
endmodule

// [core/rcg_fault_chk.sv]
`timescale 1ns/100ps
module rcg_fault_chk
   import rcg_pkg::*;
#(
   parameter int N = NUM_UNITS
) (
   input  wire logic clk,
   input  wire logic reset,
   rcg_unit_if.chk   u
);
   typedef struct packed {
      logic [N-1:0] fault;
   } rcg_fault_state_t;

   rcg_fault_state_t st_r;
   rcg_fault_state_t st_nxt;

   // One-cycle fault answer for each access to an unclocked unit
   always_comb begin
      st_nxt       = st_r;
      st_nxt.fault = u.acc_req & ~u.en;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_r.fault <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign u.fault = st_r.fault;
endmodule

// [core/rcg_top.sv]
`timescale 1ns/100ps
module rcg_top
   import rcg_pkg::*;
#(
   parameter int         N        = NUM_UNITS,
   parameter logic [1:0] MAX_RATE = RATE_500K
) (
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic [31:0]            reg_rdata,
   input  wire logic              auto_gating_select,
   input  wire logic              sleep_now,
   input  wire logic              deep_sleep_now,
   input  wire logic [N-1:0]      sleep_gate_en,
   input  wire logic [N-1:0]      deep_gate_en,
   input  wire logic [N-1:0]      unit_acc_req,
   output logic [N-1:0]           bus_fault,
   output logic [N-1:0]           unit_clk_en,
   output logic [N-1:0]           unit_clk,
   output logic [1:0]             converter_sample_rate,
   output logic                   conv_sample_tick,
   output logic                   irq
);
   typedef struct packed {
      logic [31:0]       run;
      logic [N-1:0]      stat;
      logic [N-1:0]      mask;
      logic [31:0]       rdata;
      logic              irq;
      logic [N-1:0]      en;
      logic [TICK_W-1:0] tick_cnt;
      logic              tick;
   } rcg_state_t;

   localparam logic [N-1:0] EN_RESET = N'(unit_bits(RUN_RESET));

   rcg_state_t  st_r;
   rcg_state_t  st_nxt;
   logic [N-1:0] w1c;
   logic [N-1:0] gated_acc;

   rcg_unit_if #(.N(N)) u ();

   // Store only writable bits and clamp the rate to the permitted maximum
   function automatic logic [31:0] run_wr_val(input logic [31:0] w);
      logic [31:0] v;
      v = w & RUN_WMASK;
      if (v[RATE_MSB:RATE_LSB] > MAX_RATE) begin
         v[RATE_MSB:RATE_LSB] = MAX_RATE;
      end
      return v;
   endfunction

   rcg_clk_gate #(
      .N      (N),
      .RST_EN (EN_RESET)
   ) u_gate (
      .clk   (sys_clk),
      .reset (reset),
      .u     (u.gate),
      .gclk  (unit_clk)
   );

   rcg_fault_chk #(
      .N (N)
   ) u_fault (
      .clk   (sys_clk),
      .reset (reset),
      .u     (u.chk)
   );

   assign u.en      = st_r.en;
   assign u.acc_req = unit_acc_req;
   assign gated_acc = unit_acc_req & ~st_r.en;

   always_comb begin
      st_nxt       = st_r;
      st_nxt.rdata = '0;
      st_nxt.tick  = 1'b0;
      w1c          = '0;

      // Register writes
      if (reg_wr) begin
         if (reg_addr == RUN_OFF) begin
            st_nxt.run = run_wr_val(reg_wdata);
         end else if (reg_addr == STAT_OFF) begin
            w1c = reg_wdata[N-1:0];
         end else if (reg_addr == MASK_OFF) begin
            st_nxt.mask = reg_wdata[N-1:0];
         end
      end

      // New faults win over a clearing write in the same cycle
      st_nxt.stat = (st_r.stat & ~w1c) | u.fault;

      // Register reads; unmapped addresses read zero
      if (reg_rd) begin
         if (reg_addr == RUN_OFF) begin
            st_nxt.rdata = st_r.run;
         end else if (reg_addr == STAT_OFF) begin
            st_nxt.rdata = {{(32-N){1'b0}}, st_r.stat};
         end else if (reg_addr == MASK_OFF) begin
            st_nxt.rdata = {{(32-N){1'b0}}, st_r.mask};
         end
      end

      // Unit enables: run register unless auto gating picks a sleep set
      if (auto_gating_select && deep_sleep_now) begin
         st_nxt.en = deep_gate_en;
      end else if (auto_gating_select && sleep_now) begin
         st_nxt.en = sleep_gate_en;
      end else begin
         st_nxt.en = N'(unit_bits(st_nxt.run));
      end

      st_nxt.irq = |(st_nxt.stat & st_nxt.mask);

      // Converter sample pacing from the selected rate
      if (!st_r.en[U_CONV]) begin
         st_nxt.tick_cnt = rate_cycles(st_nxt.run[RATE_MSB:RATE_LSB]) - 16'h0001;
      end else if (st_r.tick_cnt == '0) begin
         st_nxt.tick     = 1'b1;
         st_nxt.tick_cnt = rate_cycles(st_nxt.run[RATE_MSB:RATE_LSB]) - 16'h0001;
      end else begin
         st_nxt.tick_cnt = st_r.tick_cnt - 16'h0001;
      end
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         st_r.run      <= RUN_RESET;
         st_r.stat     <= STAT_RESET;
         st_r.mask     <= MASK_RESET;
         st_r.rdata    <= '0;
         st_r.irq      <= 1'b0;
         st_r.en       <= EN_RESET;
         st_r.tick_cnt <= TICK_W'(CYC_125K - 1);
         st_r.tick     <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata             = st_r.rdata;
   assign bus_fault             = u.fault;
   assign unit_clk_en           = st_r.en;
   assign converter_sample_rate = st_r.run[RATE_MSB:RATE_LSB];
   assign conv_sample_tick      = st_r.tick;
   assign irq                   = st_r.irq;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   sequence s_run_wr;
      reg_wr && (reg_addr == RUN_OFF);
   endsequence

   sequence s_run_rd;
      reg_rd && (reg_addr == RUN_OFF);
   endsequence

   sequence s_gated_acc;
      gated_acc != '0;
   endsequence

   property p_bit_wr(int b);
      s_run_wr |=> (st_r.run[b] == get_bit($past(reg_wdata), b));
   endproperty

   chk_msg_bit_wr: assert property (p_bit_wr(MSG_CTRL_CLK_EN_BIT))
      else $error("message controller gate bit not written");
   chk_pwm_bit_wr: assert property (p_bit_wr(PWM_CLK_EN_BIT))
      else $error("pulse-width gate bit not written");
   chk_conv_bit_wr: assert property (p_bit_wr(CONV_CLK_EN_BIT))
      else $error("converter gate bit not written");
   chk_keep_bit_wr: assert property (p_bit_wr(LOW_POWER_KEEPER_CLK_EN_BIT))
      else $error("keeper gate bit not written");
   chk_dog_bit_wr: assert property (p_bit_wr(DOG_TIMER_CLK_EN_BIT))
      else $error("dog timer gate bit not written");

   chk_fault_gated_acc: assert property (
      s_gated_acc |=> (bus_fault == $past(gated_acc)))
      else $error("access to unclocked unit gave no fault");

   chk_fault_sticky_set: assert property (
      s_gated_acc |=> ##1 ((st_r.stat & $past(gated_acc, 2)) == $past(gated_acc, 2)))
      else $error("fault status bit not set");

   chk_rate_max_cap: assert property (
      st_r.run[RATE_MSB:RATE_LSB] <= MAX_RATE)
      else $error("sample rate above maximum");

   chk_reserved_read_zero: assert property (
      s_run_wr |=> ((st_r.run & ~RUN_WMASK) == 32'h0000_0000))
      else $error("reserved bits not zero");

   chk_run_read_data: assert property (
      s_run_rd |=> (reg_rdata == $past(st_r.run)))
      else $error("run register read data wrong");

   chk_run_mode_en: assert property (
      !auto_gating_select |=> (unit_clk_en == N'(unit_bits(st_r.run))))
      else $error("run enables not applied");

   chk_sleep_mode_en: assert property (
      (auto_gating_select && sleep_now && !deep_sleep_now)
      |=> (unit_clk_en == $past(sleep_gate_en)))
      else $error("sleep enables not applied");

   chk_tick_gated_off: assert property (
      !st_r.en[U_CONV] |=> !conv_sample_tick)
      else $error("sample tick while converter unclocked");

   chk_no_fault_enabled: assert property (
      ((unit_acc_req & unit_clk_en) != '0)
      |=> ((bus_fault & $past(unit_acc_req & unit_clk_en)) == '0))
      else $error("fault from a clocked unit");

   chk_stat_set_wins: assert property (
      (reg_wr && (reg_addr == STAT_OFF) && (bus_fault != '0))
      |=> ((st_r.stat & $past(bus_fault)) == $past(bus_fault)))
      else $error("clearing write dropped a new fault");

   chk_rate_field_wr: assert property (
      (reg_wr && (reg_addr == RUN_OFF) && (reg_wdata[RATE_MSB:RATE_LSB] <= MAX_RATE))
      |=> (converter_sample_rate == $past(reg_wdata[RATE_MSB:RATE_LSB])))
      else $error("sample rate field not written");

   chk_deep_mode_en: assert property (
      (auto_gating_select && deep_sleep_now)
      |=> (unit_clk_en == $past(deep_gate_en)))
      else $error("deep sleep enables not applied");

   chk_rdata_idle_zero: assert property (
      !reg_rd |=> (reg_rdata == 32'h0000_0000))
      else $error("read data not zero outside a read");
endmodule

// [tb/rcg_unit_model.sv]
`timescale 1ns/100ps
module rcg_unit_model
   import rcg_pkg::*;
(
   input  wire logic                 sys_clk,
   input  wire logic [NUM_UNITS-1:0] bus_fault,
   output logic      [NUM_UNITS-1:0] unit_acc_req
);
   logic [NUM_UNITS-1:0] seen_fault;

   initial begin
      unit_acc_req = '0;
      seen_fault   = '0;
   end

   // One access cycle to the selected units; the fault answer is taken one cycle later
   task automatic access(input logic [NUM_UNITS-1:0] sel);
      @(posedge sys_clk);
      unit_acc_req <= sel;
      @(posedge sys_clk);
      unit_acc_req <= '0;
      #1;
      seen_fault = bus_fault;
   endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/100ps
module testbench import rcg_pkg::*;;
   logic                 sys_clk, reset, reg_wr, reg_rd, irq, conv_sample_tick;
   logic                 auto_gating_select, sleep_now, deep_sleep_now;
   logic [ADDR_W-1:0]    reg_addr;
   logic [31:0]          reg_wdata, reg_rdata;
   logic [NUM_UNITS-1:0] sleep_gate_en, deep_gate_en, unit_acc_req;
   logic [NUM_UNITS-1:0] bus_fault, unit_clk_en, unit_clk;
   logic [1:0]           converter_sample_rate;
   int                   errors, checked, i, n;
   int                   per[4] = '{CYC_125K, CYC_250K, CYC_500K, CYC_500K};

   rcg_top uut (.sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .auto_gating_select(auto_gating_select), .sleep_now(sleep_now),
      .deep_sleep_now(deep_sleep_now), .sleep_gate_en(sleep_gate_en),
      .deep_gate_en(deep_gate_en), .unit_acc_req(unit_acc_req), .bus_fault(bus_fault),
      .unit_clk_en(unit_clk_en), .unit_clk(unit_clk),
      .converter_sample_rate(converter_sample_rate),
      .conv_sample_tick(conv_sample_tick), .irq(irq));

   rcg_unit_model model (.sys_clk(sys_clk), .bus_fault(bus_fault),
      .unit_acc_req(unit_acc_req));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   // Cycles up to and including the next sample tick
   task automatic gap(output int cnt);
      cnt = 0;
      do begin
         @(negedge sys_clk);
         cnt++;
      end while (conv_sample_tick !== 1'b1 && cnt < 1000);
      if (cnt >= 1000) begin
         errors++;
         finish_test();
      end
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask

   initial begin
      errors = 0;
      checked = 0;
      reset = 1'b1;
      {reg_wr, reg_rd, auto_gating_select, sleep_now, deep_sleep_now} = '0;
      {reg_addr, reg_wdata, sleep_gate_en, deep_gate_en} = '0;
      repeat (4) @(posedge sys_clk);
      reset <= 1'b0;
      rd(RUN_OFF, 32'h0000_0040);
      chk(32'(unit_clk_en), 32'h02);
      cyc(1);
      chk(reg_rdata, 32'h0);
      rd(12'h0fc, 32'h0);
      $display("test reset done");
      wr(RUN_OFF, 32'hffff_ffff);
      rd(RUN_OFF, 32'h0111_0248);
      chk(32'(unit_clk_en), 32'h1f);
      cyc(1);
      chk(32'(unit_clk), 32'h1f);
      $display("test enables done");
      wr(RUN_OFF, 32'h0010_0000);
      model.access(5'h1f);
      chk(32'(model.seen_fault), 32'h17);
      wr(RUN_OFF, 32'h0);
      cyc(1);
      chk(32'(unit_clk), 32'h0);
      model.access(5'h08);
      chk(32'(model.seen_fault), 32'h08);
      cyc(1);
      rd(STAT_OFF, 32'h1f);
      chk(32'(irq), 32'h0);
      wr(MASK_OFF, 32'h1f);
      cyc(1);
      chk(32'(irq), 32'h1);
      wr(STAT_OFF, 32'h08);
      rd(STAT_OFF, 32'h17);
      wr(STAT_OFF, 32'h17);
      cyc(1);
      chk(32'(irq), 32'h0);
      // Clearing write lands in the same cycle as a new fault
      fork
         model.access(5'h08);
         begin
            @(posedge sys_clk);
            wr(STAT_OFF, 32'h08);
         end
      join
      rd(STAT_OFF, 32'h08);
      wr(STAT_OFF, 32'h08);
      $display("test faults done");
      for (i = 0; i < 4; i++) begin
         wr(RUN_OFF, 32'h0001_0000 | (32'(i) << 8));
         chk(32'(converter_sample_rate), (i > 2) ? 32'h2 : 32'(i));
         gap(n);
         gap(n);
         chk(32'(n), 32'(per[i]));
      end
      $display("test rates done");
      wr(RUN_OFF, 32'h0100_0008);
      @(posedge sys_clk);
      sleep_gate_en      <= 5'h05;
      deep_gate_en       <= 5'h0a;
      sleep_now          <= 1'b1;
      cyc(2);
      chk(32'(unit_clk_en), 32'h11);
      @(posedge sys_clk);
      auto_gating_select <= 1'b1;
      cyc(2);
      chk(32'(unit_clk_en), 32'h05);
      @(posedge sys_clk);
      deep_sleep_now     <= 1'b1;
      cyc(2);
      chk(32'(unit_clk_en), 32'h0a);
      @(posedge sys_clk);
      {auto_gating_select, sleep_now, deep_sleep_now} <= '0;
      cyc(2);
      chk(32'(unit_clk_en), 32'h11);
      $display("test sleep done");
      @(posedge sys_clk);
      reset <= 1'b1;
      repeat (2) @(posedge sys_clk);
      reset <= 1'b0;
      rd(RUN_OFF, 32'h0000_0040);
      chk(32'(unit_clk_en), 32'h02);
      chk(32'(irq), 32'h0);
      $display("test mid reset done");
      finish_test();
   end
endmodule
